// File: shared/rss_consts.vh
// constants for the reset source sequencer: offsets, fields, resets, timing
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
// register offsets (byte addresses on the plain register port)
`define RSS_ADDR_BORCTL 8'h00
`define RSS_ADDR_PWRCTL 8'h04
`define RSS_ADDR_STAT 8'h08
`define RSS_ADDR_CFG 8'h0C
// brown-out control fields
`define RSS_BC_SWEN 7
`define RSS_BC_RDY 0
// power control fields
`define RSS_PC_OVF 7
`define RSS_PC_UNF 6
`define RSS_PC_EXT 3
`define RSS_PC_RIN 2
`define RSS_PC_POR 1
`define RSS_PC_BOR 0
`define RSS_PC_MASK 8'hCF
// status fields (timeout in bit 4, powerdown in bit 3)
`define RSS_ST_TO 4
`define RSS_ST_PD 3
// configuration fields
`define RSS_CF_POWERUP_TIMER_ENABLE 0
`define RSS_CF_PINEN 1
`define RSS_CF_LVP 2
`define RSS_CF_STKEN 3
`define RSS_CF_OSTREQ 4
`define RSS_CF_MODE_LO 5
`define RSS_CF_MODE_HI 6
`define RSS_CF_PUEN 7
// reset values
`define RSS_BC_RESET 8'h80
`define RSS_PC_POR_VAL 8'h0C
`define RSS_CF_RESET 8'h03
// brown-out mode encodings
`define RSS_MODE_ON 2'h3
`define RSS_MODE_NOSLEEP 2'h2
`define RSS_MODE_SW 2'h1
`define RSS_MODE_OFF 2'h0
// vectors
`define RSS_VEC_RESET 16'h0000
`define RSS_VEC_IRQ 16'h0004
// timing
`define RSS_CLK_MHZ 125
`define RSS_POWERUP_TIMER_MS 64
`define RSS_POWERUP_TIMER_CYC (`RSS_POWERUP_TIMER_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_FILT_NS 200
`define RSS_FILT_CYC ((`RSS_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)
`endif

// File: hdl/rss_sync.v
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module rss_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // data
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_reg; // first stage, read only by second
    reg [W-1:0] s2_reg; // second stage
    // two flops in series
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
        end
    end
    assign q_o = s2_reg;
endmodule
`default_nettype wire

// File: hdl/rss_filter.v
// glitch filter: output follows input only after it stands for N cycles
`timescale 1ns/1ps
`default_nettype none
module rss_filter #(
    parameter N = 25
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // level in and filtered level out
    input wire d_i,
    output reg q_o
);
    reg [7:0] cnt_reg; // cycles the input has differed from output
    // count while the input differs, adopt it once it held long enough
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 8'h00;
            // start as held, so the pin must prove its release first
            q_o <= 1'b0;
        end else if (d_i == q_o) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg == N[7:0] - 8'h01) begin
            cnt_reg <= 8'h00;
            q_o <= d_i;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: hdl/rss_top.v
// reset source sequencer: gathers reset causes, orders start-up, keeps flags
//
// Summary of operation
// (RQ1) software brown-out enable acts only in mode 01
// (RQ2) bit 0 reads brown-out circuit ready
// (RQ3) pin reset disabled only if enable=0, lvp=0
// (RQ4) low enabled pin holds the core in reset
// (RQ5) short pin pulses are filtered out
// (RQ6) disabled pin is input, pull-up under software
// (RQ7) watchdog timeout resets, clears timeout flag
// (RQ8) reset instruction clears its flag, restarts
// (RQ9) enabled stack faults reset and set flag
// (RQ10) programming exit acts as power-on reset
// (RQ11) power-up timer optional by config bit
// (RQ12) start waits for timer, oscillator, pin
// (RQ13) timers run regardless of pin level
// (RQ14) power-on sets status 11, flags 00 110x
// (RQ15) brown-out sets status 11, clears brown-out flag
// (RQ16) pin reset clears its flag; sleep adds status
// (RQ17) watchdog wake clears both, continues at next
// (RQ18) interrupt wake sets timeout, may vector 0004h
// (RQ19) unimplemented status bits read zero
// (RQ20) four brown-out modes from mode select
// (RQ21) power-up timer holds for 64 ms
// (RQ22) software sets power-on and brown-out flags back
// (RQ23) cause flags kept until rewritten or new event
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.vh"
module rss_top #(
    parameter POWERUP_TIMER_CYC = `RSS_POWERUP_TIMER_CYC
) (
    // clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // register port
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // analog detectors and pin (asynchronous)
    input wire por_n_i,
    input wire bor_n_i,
    input wire bor_ready_i,
    input wire ext_reset_pin_n_i,
    input wire prog_mode_i,
    input wire osc_ready_i,
    // core events (same clock)
    input wire wdt_timeout_i,
    input wire sleep_i,
    input wire reset_instr_i,
    input wire stack_overflow_i,
    input wire stack_underflow_i,
    input wire irq_wake_i,
    input wire gie_i,
    // outputs to core, pad and brown-out circuit
    output reg core_reset_n_o,
    output reg [15:0] restart_vector_o,
    output reg restart_load_o,
    output reg brownout_enable_o,
    output reg pin_pullup_en_o,
    output reg pin_gpio_mode_o,
    output reg gpio_in_o
);
    ////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisation
    reg rst_s1_reg; // reset release stage one
    reg rst_reg; // synchronised active-low reset
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_reg <= rst_s1_reg;
        end
    end
    wire [5:0] async_s; // synchronised pins
    rss_sync #(.W(6)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_reg),
        .d_i({por_n_i, bor_n_i, bor_ready_i, ext_reset_pin_n_i,
              prog_mode_i, osc_ready_i}),
        .q_o(async_s)
    );
    wire por_n_s = async_s[5]; // power-on released
    wire bor_n_s = async_s[4]; // brown-out released
    wire bor_rdy_s = async_s[3]; // brown-out circuit active
    wire pin_s = async_s[2]; // pin level
    wire prog_s = async_s[1]; // programming mode
    wire osc_s = async_s[0]; // oscillator ready
    wire pin_f; // filtered pin level
    rss_filter #(.N(`RSS_FILT_CYC)) u_filt (
        .clk_i(clk_i),
        .rst_n_i(rst_reg),
        .d_i(pin_s),
        .q_o(pin_f)
    ); // [RQ5]
    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] cfg_reg; // configuration word bits
    reg swen_reg; // software brown-out enable
    localparam [7:0] BC_RST = `RSS_BC_RESET; // brown-out control reset word
    reg [7:0] power_control_register_reg; // reset cause flags
    reg to_reg; // timeout flag
    reg pd_reg; // powerdown flag
    reg bor_n_d_reg; // brown-out release, delayed
    wire [1:0] mode = cfg_reg[`RSS_CF_MODE_HI:`RSS_CF_MODE_LO];
    // pin reset function enabled
    wire pin_en = cfg_reg[`RSS_CF_PINEN] | cfg_reg[`RSS_CF_LVP]; // [RQ3]
    wire pin_low = pin_en & ~pin_f; // [RQ4]
    wire bor_evt = bor_n_d_reg & ~bor_n_s; // brown-out falling edge
    wire stk_en = cfg_reg[`RSS_CF_STKEN];
    wire ovf_evt = stk_en & stack_overflow_i; // [RQ9]
    wire unf_evt = stk_en & stack_underflow_i; // [RQ9]
    ////////////////////////////////////////////////////////////////////////
    // sequencer states
    localparam S_HOLD = 4'b0001; // power-on or brown-out held
    localparam S_POWERUP_TIMER = 4'b0010; // power-up timer running
    localparam S_WAIT = 4'b0100; // waiting for oscillator and pin
    localparam S_RUN = 4'b1000; // core running
    reg [3:0] st_reg;
    reg [3:0] st_next;
    reg [26:0] tmr_reg; // power-up timer count
    reg pin_prev_reg; // pin was holding reset last cycle
    wire tmr_done = (tmr_reg == POWERUP_TIMER_CYC[26:0] - 27'h1);
    wire osc_ok = ~cfg_reg[`RSS_CF_OSTREQ] | osc_s; // [RQ12]
    wire cold = ~por_n_s | ~bor_n_s | prog_s; // power held
    // a watchdog time-out in sleep wakes the core instead of resetting it
    wire warm = (wdt_timeout_i & ~sleep_i) | reset_instr_i | ovf_evt
        | unf_evt; // [RQ17]
    // next state
    always @* begin
        st_next = st_reg;
        case (st_reg)
            S_HOLD: begin
                if (!cold) begin
                    // [RQ11]
                    st_next = cfg_reg[`RSS_CF_POWERUP_TIMER_ENABLE] ? S_POWERUP_TIMER : S_WAIT;
                end
            end
            S_POWERUP_TIMER: begin
                if (tmr_done) begin
                    st_next = S_WAIT; // [RQ21]
                end
            end
            S_WAIT: begin
                // timers ran free; start once the oscillator is ok and the pin lets go
                if (osc_ok && !pin_low) begin
                    st_next = S_RUN; // [RQ12] [RQ13]
                end
            end
            S_RUN: begin
                if (pin_low || warm) begin
                    st_next = S_WAIT; // [RQ4] [RQ7] [RQ8]
                end
            end
            default: begin
                st_next = S_HOLD;
            end
        endcase
        if (cold) begin
            st_next = S_HOLD;
        end
    end
    // state, timer and edge history
    always @(posedge clk_i or negedge rst_reg) begin
        if (!rst_reg) begin
            st_reg <= S_HOLD;
            tmr_reg <= 27'h0;
            // same level as the synchroniser, so no false edge at release
            bor_n_d_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            bor_n_d_reg <= bor_n_s;
            pin_prev_reg <= pin_low;
            // timer counts only while in its state, never on pin level
            if (st_reg == S_POWERUP_TIMER) begin
                tmr_reg <= tmr_reg + 27'h1; // [RQ13]
            end else begin
                tmr_reg <= 27'h0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // flags and software registers
    wire wr_bc = reg_wr_i && reg_addr_i == `RSS_ADDR_BORCTL;
    wire wr_pc = reg_wr_i && reg_addr_i == `RSS_ADDR_PWRCTL;
    wire wr_st = reg_wr_i && reg_addr_i == `RSS_ADDR_STAT;
    wire wr_cf = reg_wr_i && reg_addr_i == `RSS_ADDR_CFG;
    wire pin_evt = pin_low & ~pin_prev_reg & (st_reg == S_RUN);
    wire por_hold = ~por_n_s | prog_s; // [RQ10]
    reg [7:0] power_control_register_next;
    // cause flags: hardware events win over software writes
    always @* begin
        power_control_register_next = power_control_register_reg;
        if (wr_pc) begin
            power_control_register_next = reg_wdata_i & `RSS_PC_MASK; // [RQ22]
        end
        if (por_hold) begin
            power_control_register_next = `RSS_PC_POR_VAL; // [RQ14] [RQ10]
        end else if (bor_evt) begin
            power_control_register_next[`RSS_PC_OVF] = 1'b0; // [RQ15]
            power_control_register_next[`RSS_PC_UNF] = 1'b0;
            power_control_register_next[`RSS_PC_EXT] = 1'b1;
            power_control_register_next[`RSS_PC_RIN] = 1'b1;
            power_control_register_next[`RSS_PC_BOR] = 1'b0;
        end else begin
            // events of other kinds leave the rest untouched [RQ23]
            if (pin_evt) begin
                power_control_register_next[`RSS_PC_EXT] = 1'b0; // [RQ16]
            end
            if (reset_instr_i && st_reg == S_RUN) begin
                power_control_register_next[`RSS_PC_RIN] = 1'b0; // [RQ8]
            end
            if (ovf_evt) begin
                power_control_register_next[`RSS_PC_OVF] = 1'b1; // [RQ9]
            end
            if (unf_evt) begin
                power_control_register_next[`RSS_PC_UNF] = 1'b1; // [RQ9]
            end
        end
    end
    // flag, status and control registers
    always @(posedge clk_i or negedge rst_reg) begin
        if (!rst_reg) begin
            power_control_register_reg <= `RSS_PC_POR_VAL;
            to_reg <= 1'b1;
            pd_reg <= 1'b1;
            swen_reg <= BC_RST[`RSS_BC_SWEN];
            cfg_reg <= `RSS_CF_RESET;
        end else begin
            power_control_register_reg <= power_control_register_next;
            if (wr_bc) begin
                swen_reg <= reg_wdata_i[`RSS_BC_SWEN]; // [RQ1]
            end
            if (wr_cf) begin
                cfg_reg <= reg_wdata_i;
            end
            if (wr_st) begin
                to_reg <= reg_wdata_i[`RSS_ST_TO];
                pd_reg <= reg_wdata_i[`RSS_ST_PD];
            end
            if (por_hold || bor_evt) begin
                to_reg <= 1'b1; // [RQ14] [RQ15]
                pd_reg <= 1'b1;
            end else if (sleep_i && wdt_timeout_i) begin
                to_reg <= 1'b0; // [RQ17]
                pd_reg <= 1'b0;
            end else if (sleep_i && (irq_wake_i || pin_evt)) begin
                to_reg <= 1'b1; // [RQ18] [RQ16]
                pd_reg <= 1'b0;
            end else if (wdt_timeout_i && st_reg == S_RUN) begin
                to_reg <= 1'b0; // [RQ7]
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // outputs to core, pad and brown-out circuit
    reg bor_en_c; // brown-out enable from mode
    always @* begin
        case (mode)
            `RSS_MODE_ON: bor_en_c = 1'b1; // [RQ20]
            `RSS_MODE_NOSLEEP: bor_en_c = ~sleep_i;
            `RSS_MODE_SW: bor_en_c = swen_reg; // [RQ1]
            default: bor_en_c = 1'b0;
        endcase
    end
    wire wake_evt = sleep_i & ((wdt_timeout_i) | irq_wake_i);
    // registered outputs
    always @(posedge clk_i or negedge rst_reg) begin
        if (!rst_reg) begin
            core_reset_n_o <= 1'b0;
            restart_vector_o <= `RSS_VEC_RESET;
            restart_load_o <= 1'b0;
            brownout_enable_o <= 1'b0;
            pin_pullup_en_o <= 1'b1;
            pin_gpio_mode_o <= 1'b0;
            gpio_in_o <= 1'b0;
        end else begin
            core_reset_n_o <= (st_next == S_RUN);
            brownout_enable_o <= bor_en_c;
            // disabled pin is a plain input with software pull-up [RQ6]
            pin_gpio_mode_o <= ~pin_en;
            pin_pullup_en_o <= pin_en | cfg_reg[`RSS_CF_PUEN];
            gpio_in_o <= pin_s;
            restart_load_o <= 1'b0;
            if (st_reg != S_RUN && st_next == S_RUN) begin
                restart_vector_o <= `RSS_VEC_RESET; // [RQ7] [RQ8] [RQ9]
                restart_load_o <= 1'b1;
            end else if (wake_evt && st_reg == S_RUN) begin
                // wake continues at next address, vectors when allowed
                restart_vector_o <= `RSS_VEC_IRQ; // [RQ18] [RQ17]
                restart_load_o <= irq_wake_i & gie_i & ~wdt_timeout_i;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after strobe
    always @(posedge clk_i or negedge rst_reg) begin
        if (!rst_reg) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `RSS_ADDR_BORCTL: reg_rdata_o <= {swen_reg, 6'h00,
                                                  bor_rdy_s}; // [RQ2]
                `RSS_ADDR_PWRCTL: reg_rdata_o <= power_control_register_reg; // [RQ19]
                `RSS_ADDR_STAT: reg_rdata_o <= {3'h0, to_reg, pd_reg,
                                                3'h0}; // [RQ19]
                `RSS_ADDR_CFG: reg_rdata_o <= cfg_reg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: tb/rss_top_sva.sv
// port assertions for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.vh"
module rss_top_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // detector, pin and core events
    input wire logic bor_ready_i,
    input wire logic ext_reset_pin_n_i,
    input wire logic wdt_timeout_i,
    input wire logic sleep_i,
    input wire logic reset_instr_i,
    input wire logic irq_wake_i,
    input wire logic gie_i,
    // outputs to core and pad
    input wire logic core_reset_n_o,
    input wire logic [15:0] restart_vector_o,
    input wire logic restart_load_o,
    input wire logic pin_pullup_en_o,
    input wire logic pin_gpio_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [5:0] low_cnt; // cycles the pin has stood low, saturating
    // count how long the pin has been low
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt <= 6'h00;
        end else if (ext_reset_pin_n_i) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'h3F) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end
    rdata_idle_a:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its slot");
    unmapped_read_a:
        assert property (reg_rd_i && !(reg_addr_i inside {`RSS_ADDR_BORCTL,
            `RSS_ADDR_PWRCTL, `RSS_ADDR_STAT, `RSS_ADDR_CFG})
            |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ready_bit_a:
        assert property (reg_rd_i && reg_addr_i == `RSS_ADDR_BORCTL
            && $stable(bor_ready_i) && $past(bor_ready_i, 3) == bor_ready_i
            |=> reg_rdata_o[6:0] == {6'h00, $past(bor_ready_i)})
        else $error("ready bit wrong");
    instr_reset_a:
        assert property (reset_instr_i && core_reset_n_o |=> !core_reset_n_o)
        else $error("reset instruction ignored");
    wdt_reset_a:
        assert property (wdt_timeout_i && !sleep_i && core_reset_n_o
            |=> !core_reset_n_o)
        else $error("watchdog reset missing");
    wdt_wake_a:
        assert property (wdt_timeout_i && sleep_i && core_reset_n_o
            |=> (core_reset_n_o && !restart_load_o) [*4])
        else $error("watchdog wake reset the core");
    restart_vec_a:
        assert property ($rose(core_reset_n_o) |-> restart_load_o
            && restart_vector_o == `RSS_VEC_RESET)
        else $error("restart without reset vector");
    irq_vec_a:
        assert property (irq_wake_i && sleep_i && gie_i && core_reset_n_o
            |-> ##[1:3] (restart_load_o && restart_vector_o == `RSS_VEC_IRQ))
        else $error("interrupt vector not loaded");
    pin_hold_a:
        assert property (low_cnt > 6'h1F && !pin_gpio_mode_o
            |-> !core_reset_n_o)
        else $error("core runs with pin low");
    pullup_on_a:
        assert property (!pin_gpio_mode_o |-> pin_pullup_en_o)
        else $error("pull-up off on reset pin");
    cover property ($rose(core_reset_n_o));
    cover property (restart_load_o && restart_vector_o == `RSS_VEC_IRQ);
    cover property (low_cnt > 6'h1F && pin_gpio_mode_o);
endmodule
bind rss_top rss_top_sva u_sva (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .bor_ready_i(bor_ready_i), .ext_reset_pin_n_i(ext_reset_pin_n_i),
    .wdt_timeout_i(wdt_timeout_i), .sleep_i(sleep_i),
    .reset_instr_i(reset_instr_i), .irq_wake_i(irq_wake_i), .gie_i(gie_i),
    .core_reset_n_o(core_reset_n_o), .restart_vector_o(restart_vector_o),
    .restart_load_o(restart_load_o), .pin_pullup_en_o(pin_pullup_en_o),
    .pin_gpio_mode_o(pin_gpio_mode_o)
);
`default_nettype wire

// File: tb/rss_pin_model.sv
// reset pin driver model: holds the pin low on request, else lets go
`timescale 1ns/1ps
`default_nettype none
module rss_pin_model (
    // clock
    input wire logic clk_i,
    // pad pull-up from the block
    input wire logic pullup_en_i,
    // pin level seen by the block
    output logic pin_n_o
);
    logic drv_low = 1'b1; // pin held low from power-on
    logic wander = 1'b0; // floating level, changes every cycle
    // a floating pad never keeps a clean level
    always @(posedge clk_i) begin
        wander <= ~wander;
    end
    // released pin follows the pull-up or floats
    assign pin_n_o = drv_low ? 1'b0 : (pullup_en_i ? 1'b1 : wander);
    // hold the pin low until release_pin lets it go
    task automatic hold_low();
        drv_low <= 1'b1;
    endtask
    // let go of the pin
    task automatic release_pin();
        drv_low <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/rss_top_bench.sv
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rss_consts.vh"
module rss_top_bench;
    logic clk_i = 1'b0; // system clock
    logic reset_n_i = 1'b0; // async reset
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic rd_d = 1'b0; // read taken last edge
    logic por_n_i = 1'b0;
    logic bor_n_i = 1'b1;
    logic bor_ready_i = 1'b0;
    logic prog_mode_i = 1'b0;
    logic osc_ready_i = 1'b1;
    logic sleep_i = 1'b0;
    logic gie_i = 1'b0;
    logic [4:0] evt = 5'h00; // wdt, instr, ovf, unf, irq pulses
    logic [7:0] r; // random value
    logic [31:0] cfg_t = 32'h0B0D8909; // config table, entry 0 lowest
    wire [7:0] reg_rdata_o;
    wire [15:0] restart_vector_o;
    wire core_reset_n_o, restart_load_o, brownout_enable_o;
    wire pin_pullup_en_o, pin_gpio_mode_o, pin_n, gpio_in_o;
    logic [7:0] rq[$]; // expected read data
    logic [15:0] vq[$]; // expected restart vectors
    int mismatches = 0;
    int n_compared = 0;
    always #4 clk_i = ~clk_i;
    rss_top #(.POWERUP_TIMER_CYC(20)) u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .por_n_i(por_n_i), .bor_n_i(bor_n_i),
        .bor_ready_i(bor_ready_i), .ext_reset_pin_n_i(pin_n),
        .prog_mode_i(prog_mode_i), .osc_ready_i(osc_ready_i),
        .wdt_timeout_i(evt[0]), .sleep_i(sleep_i), .reset_instr_i(evt[1]),
        .stack_overflow_i(evt[2]), .stack_underflow_i(evt[3]),
        .irq_wake_i(evt[4]), .gie_i(gie_i), .core_reset_n_o(core_reset_n_o),
        .restart_vector_o(restart_vector_o), .restart_load_o(restart_load_o),
        .brownout_enable_o(brownout_enable_o),
        .pin_pullup_en_o(pin_pullup_en_o), .pin_gpio_mode_o(pin_gpio_mode_o),
        .gpio_in_o(gpio_in_o)
    );
    rss_pin_model u_pin (
        .clk_i(clk_i), .pullup_en_i(pin_pullup_en_o), .pin_n_o(pin_n)
    );
    task automatic chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (e !== g) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic lvl(input string n, input logic e, g);
        chk(n, {15'h0, e}, {15'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        cyc(1);
        reg_wr_i <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, e);
        rq.push_back(e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        cyc(1);
        reg_rd_i <= 1'b0;
        cyc(1);
    endtask
    task automatic ev(input int b);
        evt[b] <= 1'b1;
        cyc(1);
        evt[b] <= 1'b0;
        cyc(1);
    endtask
    task automatic pin_pulse(input int n);
        u_pin.hold_low();
        cyc(n);
        u_pin.release_pin();
    endtask
    // bounded wait until every noted restart has been seen
    task automatic wait_rs(input int n);
        repeat (n) if (vq.size() != 0) cyc(1);
        if (vq.size() != 0) begin
            chk("restart_load_o", 16'h0001, 16'h0000);
            vq.delete();
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watch read data and restarts against the oldest note
    always @(posedge clk_i) begin
        if (rd_d) chk("reg_rdata_o", rq.size() ? rq.pop_front() : 8'hXX,
            reg_rdata_o);
        if (restart_load_o === 1'b1) chk("restart_vector_o",
            vq.size() ? vq.pop_front() : 16'hXXXX, restart_vector_o);
        rd_d <= reg_rd_i;
    end
    // hang guard
    initial begin
        cyc(20000);
        mismatches++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hB6AF));
        r = $urandom;
        bor_ready_i <= r[0];
        cyc(5);
        reset_n_i <= 1'b1;
        cyc(3);
        por_n_i <= 1'b1;
        cyc(80);
        lvl("core_reset_n_o", 1'b0, core_reset_n_o);
        vq.push_back(`RSS_VEC_RESET);
        u_pin.release_pin();
        wait_rs(60);
        rd(`RSS_ADDR_PWRCTL, `RSS_PC_POR_VAL);
        rd(`RSS_ADDR_STAT, 8'h18);
        rd(`RSS_ADDR_CFG, `RSS_CF_RESET);
        rd(`RSS_ADDR_BORCTL, `RSS_BC_RESET | r[0]);
        rd(8'h40, 8'h00);
        wr(`RSS_ADDR_PWRCTL, r);
        rd(`RSS_ADDR_PWRCTL, r & `RSS_PC_MASK);
        wr(`RSS_ADDR_PWRCTL, 8'h0F);
        vq.push_back(`RSS_VEC_RESET);
        ev(1);
        wait_rs(20);
        rd(`RSS_ADDR_PWRCTL, 8'h0B);
        ev(2);
        cyc(10);
        rd(`RSS_ADDR_PWRCTL, 8'h0B);
        wr(`RSS_ADDR_CFG, 8'h0B);
        for (int s = 2; s < 4; s++) begin
            vq.push_back(`RSS_VEC_RESET);
            ev(s);
            wait_rs(20);
        end
        rd(`RSS_ADDR_PWRCTL, 8'hCB);
        vq.push_back(`RSS_VEC_RESET);
        ev(0);
        wait_rs(20);
        rd(`RSS_ADDR_STAT, 8'h08);
        pin_pulse(10);
        cyc(40);
        lvl("core_reset_n_o", 1'b1, core_reset_n_o);
        sleep_i <= 1'b1;
        vq.push_back(`RSS_VEC_RESET);
        u_pin.hold_low();
        cyc(40);
        lvl("core_reset_n_o", 1'b0, core_reset_n_o);
        u_pin.release_pin();
        sleep_i <= 1'b0;
        wait_rs(60);
        rd(`RSS_ADDR_PWRCTL, 8'hC3);
        rd(`RSS_ADDR_STAT, 8'h10);
        sleep_i <= 1'b1;
        ev(0);
        cyc(5);
        rd(`RSS_ADDR_STAT, 8'h00);
        gie_i <= 1'b1;
        vq.push_back(`RSS_VEC_IRQ);
        ev(4);
        wait_rs(20);
        rd(`RSS_ADDR_STAT, 8'h10);
        sleep_i <= 1'b0;
        gie_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(`RSS_ADDR_CFG, cfg_t[i*8 +: 8]);
            // let the filtered pin settle after a pull-up change
            cyc(30);
            lvl("pin_gpio_mode_o", i < 2, pin_gpio_mode_o);
            lvl("pin_pullup_en_o", i != 0, pin_pullup_en_o);
            if (i != 0) lvl("gpio_in_o", 1'b1, gpio_in_o);
            if (i == 0) pin_pulse(40);
        end
        for (int k = 0; k < 16; k++) begin
            sleep_i <= k[3];
            wr(`RSS_ADDR_CFG, {1'b0, k[1:0], 5'h0B});
            wr(`RSS_ADDR_BORCTL, {k[2], 7'h00});
            cyc(3);
            lvl("brownout_enable_o", k[1:0] == `RSS_MODE_ON
                || (k[1:0] == `RSS_MODE_NOSLEEP && !k[3]) || (k[1:0]
                == `RSS_MODE_SW && k[2]), brownout_enable_o);
            rd(`RSS_ADDR_BORCTL, {k[2], 6'h00, r[0]});
        end
        sleep_i <= 1'b0;
        wr(`RSS_ADDR_CFG, 8'h7B);
        osc_ready_i <= 1'b0;
        bor_n_i <= 1'b0;
        cyc(10);
        bor_n_i <= 1'b1;
        cyc(60);
        lvl("core_reset_n_o", 1'b0, core_reset_n_o);
        vq.push_back(`RSS_VEC_RESET);
        osc_ready_i <= 1'b1;
        wait_rs(20);
        rd(`RSS_ADDR_PWRCTL, 8'h0E);
        rd(`RSS_ADDR_STAT, 8'h18);
        prog_mode_i <= 1'b1;
        cyc(10);
        prog_mode_i <= 1'b0;
        vq.push_back(`RSS_VEC_RESET);
        wait_rs(100);
        rd(`RSS_ADDR_PWRCTL, `RSS_PC_POR_VAL);
        rd(`RSS_ADDR_STAT, 8'h18);
        cyc(5);
        finish_test();
    end
endmodule
`default_nettype wire
